// >>> rtl/tcc_pkg.sv
/*
 * Package for the transfer controller counter and activation block: register offsets,
 * field positions, masks, transfer modes and the sequencer states.
 * Assumes a 32-bit APB register bus and a 32-bit system bus master port.
 */
// Functional notes
// - Normal mode: 16-bit count A decrements per transfer; job ends at zero.
// - Repeat mode: low byte counts down, reloads from high byte at zero.
// - Block mode: low byte counts units in block, reloads from high byte.
// - Block mode: block counter decrements after each block's last unit; zero ends job.
// - Block counter is untouched in normal and repeat modes.
// - A source with its enable bit set becomes an activation request.
// - Enable bit clears when the source's count completes, last chain entry if chained.
// - Software writing 0 clears an enable bit.
// - Writing 1 to the soft trigger sets the request flag of source 027.
// - Soft trigger with source 027 enable clear gives an ordinary CPU interrupt.
// - Soft trigger with source 027 enable set issues an activation request.
// - Soft trigger bit accepts only 1; writes of 0 do nothing.
// - Vector base top four bits ignore writes and copy bit 27.
// - Vector base low ten bits read zero; 1 KB alignment.
// - Read skip enabled skips info reload when the vector repeats.
// - Address mode bit: 0 full 32-bit, 1 short 24-bit addressing.
// - Requests are accepted only while the module run bit is 1.
// - Active flag sets on activation, clears when that transfer completes.
// - Status shows the activating vector number while active.
// - Mode field: 00 normal, 01 repeat, 10 block, 11 prohibited.
// - Mode, addresses and counts load from RAM per activation (not on a read skip) and write back after.
// - Interrupt select 1: CPU interrupt per transfer; 0: only at completion.
package tcc_pkg;
    localparam logic [7:0]  ADDR_ENABLE_BASE = 8'h00;  // Eight enable words 0x00..0x1C
    localparam logic [7:0]  ADDR_SOFT_TRIG   = 8'h20;
    localparam logic [7:0]  ADDR_VEC_BASE    = 8'h24;
    localparam logic [7:0]  ADDR_CONTROL     = 8'h28;
    localparam logic [7:0]  ADDR_ADDR_MODE   = 8'h2C;
    localparam logic [7:0]  ADDR_MODULE_RUN  = 8'h30;
    localparam logic [7:0]  ADDR_STATUS      = 8'h34;
    localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'h38;

    localparam logic [7:0]  SOFT_VECTOR      = 8'h1B;  // Source 027
    localparam int          CTRL_RRS_BIT     = 4;
    localparam int          STS_ACT_BIT      = 15;
    localparam logic [31:0] VBR_KEEP_MASK    = 32'h0FFF_FC00;

    // Info layout: word0 = mode A/B + count A, word1 = src, word2 = dst, word3 = block count
    localparam int          MRA_MD_HI        = 31;
    localparam int          MRA_MD_LO        = 30;
    localparam int          MRB_CHNE_BIT     = 23;
    localparam int          MRB_IRQ_EVERY_TRANSFER_SELECT_BIT    = 21;
    localparam logic [1:0]  MD_NORMAL        = 2'h0;
    localparam logic [1:0]  MD_REPEAT        = 2'h1;
    localparam logic [1:0]  MD_BLOCK         = 2'h2;
    localparam logic [31:0] SHORT_MASK       = 32'h00FF_FFFF;

    typedef enum logic [7:0] {
        ST_IDLE  = 8'b0000_0001,
        ST_VEC   = 8'b0000_0010,
        ST_RD    = 8'b0000_0100,
        ST_MOVE  = 8'b0000_1000,
        ST_COUNT = 8'b0001_0000,
        ST_WB    = 8'b0010_0000,
        ST_NEXT  = 8'b0100_0000,
        ST_DONE  = 8'b1000_0000
    } tcc_state_t;
endpackage : tcc_pkg

// >>> rtl/tcc_core.sv
/*
 * Counter, activation and control logic of a vector-driven transfer controller.
 * Assumes a 32-bit APB slave port, a simple single-word system bus master
 * (request held until ack), and 256 level interrupt request inputs.
 */
`timescale 1ns/1ps
module tcc_core #(
    parameter int NUM_SRC = 256
) (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               clkEn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    input  wire logic [NUM_SRC-1:0] srcRequest,
    output logic [NUM_SRC-1:0]      cpuIrq,
    output logic                    busReq,
    output logic                    busWrite,
    output logic [31:0]             busAddr,
    output logic [31:0]             busWdata,
    input  wire logic               busAck,
    input  wire logic [31:0]        busRdata
);

    ////////////////////////////////////////////////////////////////////////////////////
    // Registers and state
    logic [NUM_SRC-1:0]   activationEnable;
    logic [NUM_SRC-1:0]   softSourceRequestFlag;
    logic [31:0]          vectorBase;
    logic                 infoReadSkipEnable;
    logic                 addressMode;
    logic                 moduleRun;
    logic                 transferInProgress;
    logic [7:0]           activeVectorNumber;
    logic [7:0]           lastVector;
    logic                 lastValid;
    tcc_pkg::tcc_state_t  state;
    logic [31:0]          infoPtr;
    logic [31:0]          modeCount;
    logic [31:0]          srcAddr;
    logic [31:0]          dstAddr;
    logic [31:0]          blockWord;
    logic [31:0]          dataWord;
    logic [1:0]           wordIdx;
    logic                 movePhase;
    logic                 jobDone;

    logic       apbWr;
    logic       apbRd;
    logic [7:0] pickVec;
    logic       pickValid;
    logic [15:0] countA;
    logic [15:0] blockCount;
    logic [1:0]  mode;

    assign apbWr      = psel && penable && pwrite && clkEn;
    assign apbRd      = psel && !penable && !pwrite;
    assign countA     = modeCount[15:0];
    assign blockCount = blockWord[15:0];
    assign mode       = modeCount[tcc_pkg::MRA_MD_HI:tcc_pkg::MRA_MD_LO];

    function automatic logic [31:0] fix_addr(input logic [31:0] a, input logic shortMode);
        if (shortMode) begin
            fix_addr = {{8{a[23]}}, a[23:0]};
        end else begin
            fix_addr = a;
        end
    endfunction : fix_addr

    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] reg_addr);
        is_reg = (a == reg_addr);
    endfunction : is_reg

    ////////////////////////////////////////////////////////////////////////////////////
    // Lowest pending enabled request wins
    always_comb begin
        pickVec   = 8'h00;
        pickValid = 1'b0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if ((srcRequest[i] || softSourceRequestFlag[i]) && activationEnable[i]) begin
                pickVec   = 8'(i);
                pickValid = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait-free access, unmapped reads zero with slave error
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (clkEn) begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                pslverr <= (paddr > tcc_pkg::ADDR_STATUS) || (paddr[1:0] != 2'h0);
                prdata  <= 32'h0000_0000;
            end
            if (apbRd) begin
                if (paddr < tcc_pkg::ADDR_SOFT_TRIG && paddr[1:0] == 2'h0) begin
                    prdata <= activationEnable[paddr[4:2]*32 +: 32];
                end else if (is_reg(paddr, tcc_pkg::ADDR_VEC_BASE)) begin
                    prdata <= vectorBase;
                end else if (is_reg(paddr, tcc_pkg::ADDR_CONTROL)) begin
                    prdata <= 32'(infoReadSkipEnable) << tcc_pkg::CTRL_RRS_BIT;
                end else if (is_reg(paddr, tcc_pkg::ADDR_ADDR_MODE)) begin
                    prdata <= {31'h0000_0000, addressMode};
                end else if (is_reg(paddr, tcc_pkg::ADDR_MODULE_RUN)) begin
                    prdata <= {31'h0000_0000, moduleRun};
                end else if (is_reg(paddr, tcc_pkg::ADDR_STATUS)) begin
                    prdata <= {16'h0000, transferInProgress, 7'h00, activeVectorNumber};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            vectorBase         <= 32'h0000_0000;
            infoReadSkipEnable <= 1'b0;
            addressMode        <= 1'b0;
            moduleRun          <= 1'b0;
        end else if (apbWr) begin
            if (is_reg(paddr, tcc_pkg::ADDR_VEC_BASE)) begin
                vectorBase <= {{4{pwdata[27]}}, pwdata[27:10], 10'h000};
            end
            if (is_reg(paddr, tcc_pkg::ADDR_CONTROL)) begin
                infoReadSkipEnable <= pwdata[tcc_pkg::CTRL_RRS_BIT];
            end
            if (is_reg(paddr, tcc_pkg::ADDR_ADDR_MODE)) begin
                addressMode <= pwdata[0];
            end
            if (is_reg(paddr, tcc_pkg::ADDR_MODULE_RUN)) begin
                moduleRun <= pwdata[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Activation enables and the software source request flag
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            activationEnable      <= '0;
            softSourceRequestFlag <= '0;
        end else if (clkEn) begin
            if (apbWr && paddr < tcc_pkg::ADDR_SOFT_TRIG && paddr[1:0] == 2'h0) begin
                activationEnable[paddr[4:2]*32 +: 32] <= pwdata;
            end
            if (state == tcc_pkg::ST_DONE && jobDone) begin
                activationEnable[activeVectorNumber] <= 1'b0;
            end
            // Flag drops when the transfer picks it up or CPU interrupt delivered
            if (state == tcc_pkg::ST_VEC && activeVectorNumber == tcc_pkg::SOFT_VECTOR) begin
                softSourceRequestFlag[tcc_pkg::SOFT_VECTOR] <= 1'b0;
            end
            if (cpuIrq[tcc_pkg::SOFT_VECTOR]) begin
                softSourceRequestFlag[tcc_pkg::SOFT_VECTOR] <= 1'b0;
            end
            if (apbWr && is_reg(paddr, tcc_pkg::ADDR_SOFT_TRIG) && pwdata[0]) begin
                softSourceRequestFlag[tcc_pkg::SOFT_VECTOR] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // CPU interrupts: direct for disabled sources, from transfers otherwise
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cpuIrq <= '0;
        end else if (clkEn) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                cpuIrq[i] <= (srcRequest[i] || softSourceRequestFlag[i])
                             && !activationEnable[i] && !cpuIrq[i];
            end
            if (state == tcc_pkg::ST_DONE
                && (jobDone || modeCount[tcc_pkg::MRB_IRQ_EVERY_TRANSFER_SELECT_BIT])) begin
                cpuIrq[activeVectorNumber] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Transfer sequencer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state              <= tcc_pkg::ST_IDLE;
            transferInProgress <= 1'b0;
            activeVectorNumber <= 8'h00;
            lastVector         <= 8'h00;
            lastValid          <= 1'b0;
            infoPtr            <= 32'h0000_0000;
            modeCount          <= 32'h0000_0000;
            srcAddr            <= 32'h0000_0000;
            dstAddr            <= 32'h0000_0000;
            blockWord          <= 32'h0000_0000;
            dataWord           <= 32'h0000_0000;
            wordIdx            <= 2'h0;
            movePhase          <= 1'b0;
            jobDone            <= 1'b0;
            busReq             <= 1'b0;
            busWrite           <= 1'b0;
            busAddr            <= 32'h0000_0000;
            busWdata           <= 32'h0000_0000;
        end else if (clkEn) begin
            case (state)
                tcc_pkg::ST_IDLE: begin
                    if (pickValid && moduleRun) begin
                        transferInProgress <= 1'b1;
                        activeVectorNumber <= pickVec;
                        busReq   <= 1'b1;
                        busWrite <= 1'b0;
                        busAddr  <= vectorBase + {22'h000000, pickVec, 2'h0};
                        state    <= tcc_pkg::ST_VEC;
                    end
                end
                tcc_pkg::ST_VEC: begin
                    if (busAck) begin
                        busReq  <= 1'b0;
                        infoPtr <= busRdata;
                        wordIdx <= 2'h0;
                        if (infoReadSkipEnable && lastValid
                            && lastVector == activeVectorNumber) begin
                            state <= tcc_pkg::ST_MOVE;
                        end else begin
                            state <= tcc_pkg::ST_RD;
                        end
                    end
                end
                tcc_pkg::ST_RD: begin
                    busReq   <= 1'b1;
                    busWrite <= 1'b0;
                    busAddr  <= infoPtr + {28'h0000000, wordIdx, 2'h0};
                    if (busReq && busAck) begin
                        busReq <= 1'b0;
                        case (wordIdx)
                            2'h0: modeCount <= busRdata;
                            2'h1: srcAddr   <= busRdata;
                            2'h2: dstAddr   <= busRdata;
                            default: blockWord <= busRdata;
                        endcase
                        wordIdx <= wordIdx + 2'h1;
                        if (wordIdx == 2'h3) begin
                            state <= tcc_pkg::ST_MOVE;
                        end
                    end
                end
                tcc_pkg::ST_MOVE: begin
                    busReq   <= 1'b1;
                    busWrite <= movePhase;
                    busAddr  <= fix_addr(movePhase ? dstAddr : srcAddr, addressMode);
                    busWdata <= dataWord;
                    if (busReq && busAck) begin
                        busReq <= 1'b0;
                        if (!movePhase) begin
                            dataWord  <= busRdata;
                            movePhase <= 1'b1;
                        end else begin
                            movePhase <= 1'b0;
                            state     <= tcc_pkg::ST_COUNT;
                        end
                    end
                end
                tcc_pkg::ST_COUNT: begin
                    jobDone <= 1'b0;
                    case (mode)
                        tcc_pkg::MD_NORMAL: begin
                            modeCount[15:0] <= countA - 16'h0001;
                            jobDone <= (countA == 16'h0001);
                        end
                        tcc_pkg::MD_REPEAT: begin
                            if (countA[7:0] == 8'h01) begin
                                modeCount[7:0] <= countA[15:8];
                            end else begin
                                modeCount[7:0] <= countA[7:0] - 8'h01;
                            end
                        end
                        tcc_pkg::MD_BLOCK: begin
                            if (countA[7:0] == 8'h01) begin
                                modeCount[7:0]  <= countA[15:8];
                                blockWord[15:0] <= blockCount - 16'h0001;
                                jobDone <= (blockCount == 16'h0001);
                                state   <= tcc_pkg::ST_WB;
                            end else begin
                                modeCount[7:0] <= countA[7:0] - 8'h01;
                                state   <= tcc_pkg::ST_MOVE;
                            end
                        end
                        default: ;  // Prohibited setting: counters left as they are
                    endcase
                    if (mode != tcc_pkg::MD_BLOCK) begin
                        state <= tcc_pkg::ST_WB;
                    end
                    wordIdx <= 2'h0;
                end
                tcc_pkg::ST_WB: begin
                    busReq   <= 1'b1;
                    busWrite <= 1'b1;
                    busAddr  <= infoPtr + {28'h0000000, wordIdx, 2'h0};
                    case (wordIdx)
                        2'h0: busWdata <= modeCount;
                        2'h1: busWdata <= srcAddr;
                        2'h2: busWdata <= dstAddr;
                        default: busWdata <= blockWord;
                    endcase
                    if (busReq && busAck) begin
                        busReq  <= 1'b0;
                        wordIdx <= wordIdx + 2'h1;
                        if (wordIdx == 2'h3) begin
                            state <= tcc_pkg::ST_NEXT;
                        end
                    end
                end
                tcc_pkg::ST_NEXT: begin
                    // Chained entries follow at the next 16-byte slot
                    if (modeCount[tcc_pkg::MRB_CHNE_BIT]) begin
                        infoPtr <= infoPtr + 32'h0000_0010;
                        wordIdx <= 2'h0;
                        state   <= tcc_pkg::ST_RD;
                    end else begin
                        state   <= tcc_pkg::ST_DONE;
                    end
                end
                tcc_pkg::ST_DONE: begin
                    transferInProgress <= 1'b0;
                    lastVector         <= activeVectorNumber;
                    lastValid          <= 1'b1;
                    busWrite           <= 1'b0;
                    state              <= tcc_pkg::ST_IDLE;
                end
                default: state <= tcc_pkg::ST_IDLE;
            endcase
        end
    end

endmodule : tcc_core

// >>> testbench/tcc_core_monitor.sv
/* Port checker for tcc_core: APB answer timing, register read forms, system-bus handshake.
   Assumes one clock, reset async active high; bound to every tcc_core instance. */
`timescale 1ns/1ps
module tcc_core_monitor (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        busReq,
    input wire logic        busAck,
    input wire logic        busWrite,
    input wire logic [31:0] busAddr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_setup; psel && !penable; endsequence
    sequence s_done; psel && penable && pready; endsequence
    sequence s_read(logic [7:0] a); s_done ##0 (!pwrite && paddr == a); endsequence
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_unmapped_err: assert property (s_done ##0 (paddr > 8'h34) |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (s_done ##0 (paddr <= 8'h34 && paddr[1:0] == 2'b00) |-> !pslverr)
        else $error("mapped access refused");
    a_vbase_form: assert property (s_read(tcc_pkg::ADDR_VEC_BASE) |->
        prdata[9:0] == 10'h000 && prdata[31:28] == {4{prdata[27]}}) else $error("vector base form");
    a_trig_reads_zero: assert property (s_read(tcc_pkg::ADDR_SOFT_TRIG) |-> !prdata[0])
        else $error("trigger reads one");
    a_bus_hold: assert property (busReq && !busAck |=> busReq && $stable(busAddr) && $stable(busWrite))
        else $error("bus request not held");
    a_bus_drop: assert property (busReq && busAck |=> !busReq) else $error("bus request after ack");
endmodule : tcc_core_monitor
bind tcc_core tcc_core_monitor mon_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .busReq(busReq), .busAck(busAck), .busWrite(busWrite), .busAddr(busAddr));

// >>> testbench/tcc_mem_model.sv
/* System memory on the far side of the core's bus port.
   Assumes requests held until ack; latency cycles 0, 1, 2; released data is inverted. */
`timescale 1ns/1ps
module tcc_mem_model (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        busReq,
    input wire logic        busWrite,
    input wire logic [31:0] busAddr,
    input wire logic [31:0] busWdata,
    output logic            busAck,
    output logic [31:0]     busRdata
);
    logic [31:0] mem [logic [31:0]];
    int          waitN;
    int          lat;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            busAck <= 1'b0;
            busRdata <= 32'h5A5A_A5A5;
            waitN <= 0;
            lat <= 0;
        end else if (busAck) begin
            busAck <= 1'b0;
            busRdata <= ~busRdata;
            if (busWrite) mem[busAddr] = busWdata;
            lat <= (lat + 1) % 3;
            waitN <= (lat + 1) % 3;
        end else if (busReq && waitN > 0) begin
            waitN <= waitN - 1;
            busRdata <= ~busRdata;
        end else if (busReq) begin
            busAck <= 1'b1;
            busRdata <= mem.exists(busAddr) ? mem[busAddr] : 32'h0;
        end else begin
            busRdata <= ~busRdata;
        end
    end
endmodule : tcc_mem_model

// >>> testbench/test_transfer_counters_and_activation.sv
/* Self-checking bench: registers over APB, soft trigger, counters in three modes.
   Assumes the memory model answers the core's bus; soft vector entry at base + 0x6C. */
`timescale 1ns/1ps
module test_transfer_counters_and_activation;
    logic clk = 0, reset = 1, clkEn = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rdErr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, busAddr, busWdata, busRdata, seed = 32'h18;
    logic busReq, busWrite, busAck, rq0 = 0;
    logic [255:0] srcRequest = '0, cpuIrq;
    int errors = 0, n_tests = 0, irqs = 0, reqs = 0, w0, w3, en, i0, r0;
    logic [1:0] md [3] = '{2'h0, 2'h1, 2'h2};
    logic [15:0] cnt [3] = '{16'h0002, 16'h0301, 16'h0202};
    int blk [3] = '{5, 5, 2}, acts [3] = '{2, 1, 1};
    always #4 clk = ~clk;
    always @(posedge clk) begin
        rq0 <= busReq;
        if (busReq === 1'b1 && rq0 !== 1'b1) reqs++;
        if (cpuIrq[27] === 1'b1) irqs++;
    end
    tcc_core dut_u (.clk(clk), .reset(reset), .clkEn(clkEn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .srcRequest(srcRequest), .cpuIrq(cpuIrq), .busReq(busReq),
        .busWrite(busWrite), .busAddr(busAddr), .busWdata(busWdata), .busAck(busAck),
        .busRdata(busRdata));
    tcc_mem_model mem_u (.clk(clk), .reset(reset), .busReq(busReq), .busWrite(busWrite),
        .busAddr(busAddr), .busWdata(busWdata), .busAck(busAck), .busRdata(busRdata));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk); psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk); penable <= 1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 50) begin errors++; tally_and_finish; end
        rd = prdata; rdErr = pslverr; psel <= 0; penable <= 0;
    endtask : apb
    task automatic fire_and_wait(input logic trig);
        int i;
        r0 = reqs;
        if (trig) apb(1, tcc_pkg::ADDR_SOFT_TRIG, 32'h1);
        for (i = 0; i < 300; i++) begin
            apb(0, tcc_pkg::ADDR_STATUS, 32'h0);
            if (rd[15] === 1'b1) check({24'h0, rd[7:0]}, {24'h0, tcc_pkg::SOFT_VECTOR});
            else if (reqs > r0) break;
        end
        if (i == 300) begin errors++; tally_and_finish; end
    endtask : fire_and_wait
    task automatic model(input logic [1:0] m);
        int lo, hi;
        lo = w0 & 255; hi = (w0 >> 8) & 255;
        if (m == 2'h0) begin w0 = (w0 - 1) & 16'hFFFF; en = (w0 != 0); end
        else if (m == 2'h1) begin lo--; if (lo == 0) lo = hi; w0 = hi * 256 + lo; en = 1; end
        else begin
            do lo--; while (lo != 0);
            w3--; w0 = hi * 256 + hi; en = (w3 != 0);
        end
    endtask : model
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        reset <= 0;
        apb(1, tcc_pkg::ADDR_VEC_BASE, 32'hA000_0400); apb(0, tcc_pkg::ADDR_VEC_BASE, 32'h0);
        check(rd, 32'h0000_0400);
        apb(1, tcc_pkg::ADDR_VEC_BASE, 32'h0800_0400); apb(0, tcc_pkg::ADDR_VEC_BASE, 32'h0);
        check(rd, 32'hF800_0400);
        apb(1, tcc_pkg::ADDR_VEC_BASE, 32'h0000_0400);
        apb(1, tcc_pkg::ADDR_CONTROL, 32'h10); apb(0, tcc_pkg::ADDR_CONTROL, 32'h0);
        check(rd, 32'h10);
        apb(1, tcc_pkg::ADDR_CONTROL, 32'h0); apb(1, tcc_pkg::ADDR_ADDR_MODE, 32'h1);
        apb(0, tcc_pkg::ADDR_ADDR_MODE, 32'h0); check(rd, 32'h1);
        apb(0, 8'h40, 32'h0); check({rd[31:1], rdErr}, 32'h1);
        apb(1, tcc_pkg::ADDR_MODULE_RUN, 32'h1); i0 = irqs;
        apb(1, tcc_pkg::ADDR_SOFT_TRIG, 32'h0); repeat (10) @(posedge clk);
        check(irqs, i0);
        apb(1, tcc_pkg::ADDR_SOFT_TRIG, 32'h1); repeat (10) @(posedge clk);
        check(irqs, i0 + 1); check(reqs, 0);
        mem_u.mem[32'h46C] = 32'h800;
        for (int k = 0; k < 3; k++) begin
            w0 = cnt[k]; w3 = blk[k];
            mem_u.mem[32'h800] = {md[k], 14'h0, cnt[k]};
            mem_u.mem[32'h804] = 32'h80_0900; mem_u.mem[32'h808] = 32'hA00;
            mem_u.mem[32'h80C] = blk[k]; mem_u.mem[32'hFF80_0900] = xs(); i0 = irqs;
            apb(1, tcc_pkg::ADDR_ENABLE_BASE, 32'h0800_0000);
            if (k == 0) begin
                apb(1, tcc_pkg::ADDR_MODULE_RUN, 32'h0); apb(1, tcc_pkg::ADDR_SOFT_TRIG, 32'h1);
                r0 = reqs; repeat (20) @(posedge clk);
                check(reqs, r0);
                apb(1, tcc_pkg::ADDR_MODULE_RUN, 32'h1);
            end
            for (int a = 0; a < acts[k]; a++) begin
                fire_and_wait(k > 0 || a > 0);
                model(md[k]);
                if (a == 0) check(mem_u.mem[32'hA00], mem_u.mem[32'hFF80_0900]);
                check({16'h0, mem_u.mem[32'h800][15:0]}, w0);
                check({16'h0, mem_u.mem[32'h80C][15:0]}, w3);
                apb(0, tcc_pkg::ADDR_ENABLE_BASE, 32'h0);
                check({31'h0, rd[27]}, en);
            end
            if (k == 0) check(irqs, i0 + 1);
        end
        apb(1, tcc_pkg::ADDR_ENABLE_BASE, 32'h0); apb(0, tcc_pkg::ADDR_ENABLE_BASE, 32'h0);
        check(rd, 32'h0);
        tally_and_finish;
    end
    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        tally_and_finish;
    end
endmodule : test_transfer_counters_and_activation
